// ==== logic/mic_input_ctrl.sv ====
// modulator input control for four filter channels, apb register access
// assumes modulator clock/data pins are synchronous to clk; the filter
// clock leaves as a one-cycle strobe in the clk domain with its data bit
//
// The register offsets and the APB interface to the registers were decided locally.
`timescale 1ns/10ps
`default_nettype none

module mic_input_ctrl #(
  parameter int NCH = mic_pkg::NCH
) (
  // clock and reset
  input  wire logic              clk,
  input  wire logic              reset,
  // apb slave
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [11:0]       paddr,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  // modulator pins, the clock pin is two-way
  input  wire logic [NCH-1:0]    modulator_data_pin,
  input  wire logic [NCH-1:0]    modulator_clock_pin_i,
  output logic      [NCH-1:0]    modulator_clock_pin_o,
  output logic      [NCH-1:0]    modulator_clock_pin_oe,
  // to the downstream filter units
  output logic      [NCH-1:0]    filter_strobe,
  output logic      [NCH-1:0]    filter_data
);

  // first zero after a one, followed later by another one
  function automatic logic [4:0] gap_search(
    input logic [mic_pkg::HIST_W-1:0] h
  );
    logic       seen;
    logic       gap;
    logic       hit;
    logic [3:0] z;
    seen = 1'b0;
    gap  = 1'b0;
    hit  = 1'b0;
    z    = 4'h0;
    for (int i = 0; i < mic_pkg::HIST_W; i++) begin
      if (!hit) begin
        if (h[i]) begin
          hit  = gap;
          seen = 1'b1;
        end else if (seen && !gap) begin
          gap = 1'b1;
          z   = 4'(i);
        end
      end
    end
    return {hit, z};
  endfunction : gap_search

  // apb decode shared by the read mux and write path
  function automatic logic addr_ok(input logic [11:0] a);
    return (a < mic_pkg::MAP_TOP) && (a[1:0] == 2'h0) &&
           (a[3:2] != 2'h3);
  endfunction : addr_ok

  logic                         pready_r;
  logic                         pslverr_r;
  logic [31:0]                  prdata_r;
  logic                         xfer;
  logic [1:0]                   rsel_ch;
  logic [1:0]                   rsel_idx;

  mic_pkg::mic_cfg_s            cfg_r     [NCH];
  logic [mic_pkg::HIST_W-1:0]   hist_r    [NCH];
  logic                         last_r    [NCH];
  logic                         stky_r    [NCH];
  logic                         strobe_r  [NCH];
  logic                         data_r    [NCH];
  logic                         clk_out_r [NCH];
  logic                         clk_oe_r  [NCH];

  assign rsel_ch  = paddr[5:4];
  assign rsel_idx = paddr[3:2];
  // a transfer completes at the edge where pready is seen high
  assign xfer     = psel && penable && pready_r;

  // one wait state so read data can come from a flop
  always_ff @(posedge clk) begin
    if (reset) begin
      pready_r  <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r  <= 32'h0000_0000;
    end else begin
      pready_r  <= psel && penable && !pready_r;
      pslverr_r <= psel && penable && !pready_r && !addr_ok(paddr);
      prdata_r  <= 32'h0000_0000;
      if (psel && penable && !pready_r && !pwrite && addr_ok(paddr)) begin
        case (rsel_idx)
          mic_pkg::IDX_CTRL: begin
            prdata_r[mic_pkg::CTRL_MODE_LSB +: 2] <= cfg_r[rsel_ch].mode;
            prdata_r[mic_pkg::CTRL_CD_BIT] <= cfg_r[rsel_ch].drive_out;
            prdata_r[mic_pkg::CTRL_HIST_LSB +: mic_pkg::HIST_W] <=
              hist_r[rsel_ch];
          end
          mic_pkg::IDX_CLKDIV: begin
            prdata_r[mic_pkg::DIV_LSB +: mic_pkg::DIV_W] <=
              cfg_r[rsel_ch].div_sel;
          end
          mic_pkg::IDX_STATUS: begin
            prdata_r[mic_pkg::STAT_LAST_BIT] <= last_r[rsel_ch];
            prdata_r[mic_pkg::STAT_STKY_BIT] <= stky_r[rsel_ch];
          end
          default: begin
            prdata_r <= 32'h0000_0000;
          end
        endcase
      end
    end
  end

  assign pready  = pready_r;
  assign pslverr = pslverr_r;
  assign prdata  = prdata_r;

  for (genvar c = 0; c < NCH; c++) begin : g_ch
    logic                              sel_w;
    logic                              clk_q_r;
    logic                              clk_rise;
    logic                              clk_fall;
    logic [2:0]                        msync_r;
    logic                              m_edge;
    logic [mic_pkg::CNT_W-1:0]         gap_cnt_r;
    logic [mic_pkg::TRANS_W-1:0]       trans_r;
    logic [mic_pkg::HIST_W-1:0]        work_r;
    logic [3:0]                        thr_r;
    logic                              thr_ok_r;
    logic                              half_r;
    logic [4:0]                        srch;
    logic [mic_pkg::DIV_W-1:0]         div_cnt_r;
    logic                              div_tick;
    logic                              second_r;
    mic_pkg::mic_cal_e                 cal_r;

    assign sel_w    = xfer && pwrite && addr_ok(paddr) &&
                      (rsel_ch == 2'(c));
    assign clk_rise = modulator_clock_pin_i[c] && !clk_q_r;
    assign clk_fall = !modulator_clock_pin_i[c] && clk_q_r;
    // only the second and third sync stages are compared
    assign m_edge   = msync_r[2] ^ msync_r[1];
    assign srch     = gap_search(work_r);
    assign div_tick = (div_cnt_r == cfg_r[c].div_sel);

    // software configuration
    always_ff @(posedge clk) begin
      if (reset) begin
        cfg_r[c] <= mic_pkg::CFG_RST;
      end else if (sel_w && rsel_idx == mic_pkg::IDX_CTRL) begin
        cfg_r[c].mode      <= mic_pkg::mic_mode_e'(
          pwdata[mic_pkg::CTRL_MODE_LSB +: 2]);
        cfg_r[c].drive_out <= pwdata[mic_pkg::CTRL_CD_BIT];
      end else if (sel_w && rsel_idx == mic_pkg::IDX_CLKDIV) begin
        cfg_r[c].div_sel <= pwdata[mic_pkg::DIV_LSB +: mic_pkg::DIV_W];
      end
    end

    // modulator clock edge detect, pin taken as synchronous
    always_ff @(posedge clk) begin
      if (reset) begin
        clk_q_r <= 1'b0;
      end else begin
        clk_q_r <= modulator_clock_pin_i[c];
      end
    end

    // manchester input synchroniser
    always_ff @(posedge clk) begin
      if (reset) begin
        msync_r <= 3'h0;
      end else begin
        msync_r <= {msync_r[1:0], modulator_data_pin[c]};
      end
    end

    // system clock divider and modulator clock drive for mode 3
    always_ff @(posedge clk) begin
      if (reset) begin
        div_cnt_r    <= 3'h0;
        clk_out_r[c] <= 1'b0;
        clk_oe_r[c]  <= 1'b0;
      end else begin
        div_cnt_r <= div_tick ? 3'h0 : div_cnt_r + 3'h1;
        if (div_tick) begin
          clk_out_r[c] <= !clk_out_r[c];
        end
        clk_oe_r[c] <= (cfg_r[c].mode == mic_pkg::MODE_SYS_DIV) &&
                       cfg_r[c].drive_out;
      end
    end

    // calibration sequencer
    always_ff @(posedge clk) begin
      if (reset) begin
        cal_r <= mic_pkg::CAL_OFF;
      end else begin
        case (cal_r)
          mic_pkg::CAL_OFF: begin
            if (cfg_r[c].mode == mic_pkg::MODE_MANCH) begin
              cal_r <= mic_pkg::CAL_RUN;
            end
          end
          mic_pkg::CAL_RUN: begin
            if (cfg_r[c].mode != mic_pkg::MODE_MANCH) begin
              cal_r <= mic_pkg::CAL_OFF;
            end else if (m_edge && trans_r == mic_pkg::CAL_LAST) begin
              cal_r <= mic_pkg::CAL_EVAL;
            end
          end
          mic_pkg::CAL_EVAL: begin
            cal_r <= (cfg_r[c].mode == mic_pkg::MODE_MANCH) ?
                     mic_pkg::CAL_RUN : mic_pkg::CAL_OFF;
          end
          default: begin
            cal_r <= mic_pkg::CAL_OFF;
          end
        endcase
      end
    end

    // interval timing and working histogram
    always_ff @(posedge clk) begin
      if (reset) begin
        gap_cnt_r <= 4'h0;
        trans_r   <= 10'h000;
        work_r    <= 11'h000;
      end else if (cal_r != mic_pkg::CAL_RUN) begin
        gap_cnt_r <= 4'h0;
        trans_r   <= 10'h000;
        work_r    <= 11'h000;
      end else if (m_edge) begin
        gap_cnt_r <= 4'h0;
        trans_r   <= trans_r + 10'h001;
        // the first edge of a cycle only starts the timing, no interval yet
        if (trans_r != 10'h000 && gap_cnt_r < 4'(mic_pkg::HIST_W)) begin
          work_r[gap_cnt_r] <= 1'b1;
        end
      end else if (gap_cnt_r != mic_pkg::CNT_MAX) begin
        gap_cnt_r <= gap_cnt_r + 4'h1;
      end
    end

    // end of cycle results: histogram, threshold, fail flags
    always_ff @(posedge clk) begin
      if (reset) begin
        hist_r[c] <= 11'h000;
        last_r[c] <= 1'b0;
        thr_r     <= 4'h0;
        thr_ok_r  <= 1'b0;
      end else if (cal_r == mic_pkg::CAL_EVAL) begin
        hist_r[c] <= work_r;
        last_r[c] <= !srch[4];
        if (srch[4]) begin
          thr_r    <= srch[3:0];
          thr_ok_r <= 1'b1;
        end
      end
    end

    // sticky fail: a failing evaluation wins over a clearing read
    always_ff @(posedge clk) begin
      if (reset) begin
        stky_r[c] <= 1'b0;
      end else if (cal_r == mic_pkg::CAL_EVAL && !srch[4]) begin
        stky_r[c] <= 1'b1;
      end else if (xfer && !pwrite && addr_ok(paddr) &&
                   rsel_ch == 2'(c) &&
                   rsel_idx == mic_pkg::IDX_STATUS) begin
        stky_r[c] <= 1'b0;
      end
    end

    // filter strobe and data per input mode
    always_ff @(posedge clk) begin
      if (reset) begin
        strobe_r[c] <= 1'b0;
        data_r[c]   <= 1'b0;
        half_r      <= 1'b0;
        second_r    <= 1'b0;
      end else begin
        strobe_r[c] <= 1'b0;
        case (cfg_r[c].mode)
          mic_pkg::MODE_CLK_RISE: begin
            if (clk_rise) begin
              strobe_r[c] <= 1'b1;
              data_r[c]   <= modulator_data_pin[c];
            end
          end
          mic_pkg::MODE_CLK_BOTH: begin
            if (clk_rise || clk_fall) begin
              strobe_r[c] <= 1'b1;
              data_r[c]   <= modulator_data_pin[c];
            end
          end
          mic_pkg::MODE_MANCH: begin
            // clock pin not looked at here
            if (m_edge && thr_ok_r) begin
              if (gap_cnt_r >= thr_r || half_r) begin
                strobe_r[c] <= 1'b1;
                data_r[c]   <= msync_r[1];
                half_r      <= 1'b0;
              end else begin
                half_r <= 1'b1;
              end
            end
          end
          mic_pkg::MODE_SYS_DIV: begin
            if (div_tick && !clk_out_r[c]) begin
              second_r <= !second_r;
              if (second_r) begin
                strobe_r[c] <= 1'b1;
                data_r[c]   <= modulator_data_pin[c];
              end
            end
          end
          default: begin
            strobe_r[c] <= 1'b0;
          end
        endcase
      end
    end

    // single strobe is the only rate reference for downstream units
    assign filter_strobe[c]          = strobe_r[c];
    assign filter_data[c]            = data_r[c];
    assign modulator_clock_pin_o[c]  = clk_out_r[c];
    assign modulator_clock_pin_oe[c] = clk_oe_r[c];
  end

endmodule : mic_input_ctrl

`default_nettype wire

// ==== logic/mic_pkg.sv ====
// package for the modulator input control block: map, fields, types
// assumes a 32-bit apb slave with one aligned word per register
package mic_pkg;

  localparam int NCH = 4;
  localparam int HIST_W = 11;
  localparam int CNT_W = 4;
  localparam int TRANS_W = 10;
  localparam int DIV_W = 3;

  // per-channel register window, four words each
  localparam logic [11:0] CH_STRIDE  = 12'h0010;
  localparam logic [11:0] MAP_TOP    = 12'h0040;
  localparam logic [1:0]  IDX_CTRL   = 2'h0;
  localparam logic [1:0]  IDX_CLKDIV = 2'h1;
  localparam logic [1:0]  IDX_STATUS = 2'h2;

  // field positions
  localparam int CTRL_MODE_LSB = 0;
  localparam int CTRL_CD_BIT   = 2;
  localparam int CTRL_HIST_LSB = 16;
  localparam int DIV_LSB       = 0;
  localparam int STAT_LAST_BIT = 0;
  localparam int STAT_STKY_BIT = 1;

  // transitions gathered per calibration cycle
  localparam logic [TRANS_W-1:0] CAL_LAST = 10'h03FF;
  localparam logic [CNT_W-1:0]   CNT_MAX  = 4'hF;

  typedef enum logic [1:0] {
    MODE_CLK_RISE = 2'h0,
    MODE_CLK_BOTH = 2'h1,
    MODE_MANCH    = 2'h2,
    MODE_SYS_DIV  = 2'h3
  } mic_mode_e;

  typedef enum logic [2:0] {
    CAL_OFF  = 3'b001,
    CAL_RUN  = 3'b010,
    CAL_EVAL = 3'b100
  } mic_cal_e;

  typedef struct packed {
    mic_mode_e        mode;
    logic             drive_out;
    logic [DIV_W-1:0] div_sel;
  } mic_cfg_s;

  localparam mic_cfg_s CFG_RST = '{MODE_CLK_RISE, 1'b0, 3'h0};

endpackage : mic_pkg

// ==== tb/mic_input_ctrl_sva.sv ====
// checker for the input control block: apb answer and pin relations
// assumes one clk domain with synchronous active-high reset
`timescale 1ns/10ps
`default_nettype none
module mic_input_ctrl_sva #(
  parameter int NCH = mic_pkg::NCH
) (
  // clock, reset, apb
  input wire logic           clk,
  input wire logic           reset,
  input wire logic           psel,
  input wire logic           penable,
  input wire logic           pwrite,
  input wire logic [11:0]    paddr,
  input wire logic [31:0]    pwdata,
  input wire logic [31:0]    prdata,
  input wire logic           pready,
  input wire logic           pslverr,
  // modulator pins and filter side
  input wire logic [NCH-1:0] modulator_data_pin,
  input wire logic [NCH-1:0] modulator_clock_pin_i,
  input wire logic [NCH-1:0] modulator_clock_pin_o,
  input wire logic [NCH-1:0] modulator_clock_pin_oe,
  input wire logic [NCH-1:0] filter_strobe,
  input wire logic [NCH-1:0] filter_data
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  sequence s_wait;
    psel && penable && !pready;
  endsequence
  sequence s_done;
    psel && penable && pready;
  endsequence
  a_apb_answer: assert property (s_wait |=> pready)
    else $error("no ready one cycle into access");
  a_ready_access: assert property (pready |-> psel && penable)
    else $error("ready outside an access");
  a_rdata_idle: assert property (!pready |-> prdata == 32'h0000_0000)
    else $error("read data outside ready");
  a_err_ready: assert property (pslverr |-> pready)
    else $error("error without ready");
  a_err_hole: assert property (s_done ##0 (paddr >= 12'h040 ||
    paddr[3:2] == 2'h3) |-> pslverr && prdata == 32'h0000_0000)
    else $error("unmapped access not refused");
  a_map_ok: assert property (s_done ##0 (paddr < 12'h040 &&
    paddr[3:2] != 2'h3 && paddr[1:0] == 2'h0) |-> !pslverr)
    else $error("mapped access refused");
  a_oe_cause: assert property ($changed(modulator_clock_pin_oe) |->
    $past(pready && pwrite) || $past(pready && pwrite, 2))
    else $error("pin drive changed without a write");
  a_data_hold: assert property (((filter_data ^ $past(filter_data)) &
    ~filter_strobe) == '0)
    else $error("filter data moved without strobe");
endmodule : mic_input_ctrl_sva

bind mic_input_ctrl mic_input_ctrl_sva #(.NCH(NCH)) u_sva (
  .clk(clk), .reset(reset), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr),
  .modulator_data_pin(modulator_data_pin),
  .modulator_clock_pin_i(modulator_clock_pin_i),
  .modulator_clock_pin_o(modulator_clock_pin_o),
  .modulator_clock_pin_oe(modulator_clock_pin_oe),
  .filter_strobe(filter_strobe), .filter_data(filter_data));
`default_nettype wire

// ==== tb/mic_mod_model.sv ====
// modulator stand-in: clocked bit stream, manchester stream or slow toggle
// assumes clk is the system clock; sel 0 means no frame is running
`timescale 1ns/10ps
`default_nettype none
module mic_mod_model (
  // system side
  input  wire logic       clk,
  input  wire logic [1:0] sel,
  // modulator pins
  output logic            mclk,
  output logic            mdat
);
  logic [7:0] pat_r = 8'h35;
  int         t_r   = 0;
  initial mclk = 1'b0;
  initial mdat = 1'b0;
  always @(posedge clk) begin
    t_r <= (t_r == 11) ? 0 : t_r + 1;
    case (sel)
      2'h1: begin
        if (t_r % 4 == 3) mclk <= ~mclk;
        if (t_r % 4 == 3 && mclk) begin
          mdat  <= pat_r[0];
          pat_r <= {pat_r[0], pat_r[7:1]};
        end
      end
      2'h2: begin
        // stray clock on the pin, which manchester decoding must ignore
        if (t_r % 4 == 3) mclk <= ~mclk;
        if (t_r % 3 == 0) mdat <= (t_r % 6 == 0) ? ~pat_r[0] : pat_r[0];
        if (t_r % 6 == 3) pat_r <= {pat_r[0], pat_r[7:1]};
      end
      2'h3: if (t_r == 0) mdat <= ~mdat;
      // released line: clock stands, data never keeps a stale level
      default: mdat <= ~mdat;
    endcase
  end
endmodule : mic_mod_model
`default_nettype wire

// ==== tb/testbench.sv ====
// self-checking bench: apb register access and the four input modes
// assumes the stand-in drives every channel's pins alike
`timescale 1ns/10ps
`default_nettype none
module testbench;
  logic        clk = 1'b0;
  logic        reset = 1'b1;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata, q;
  logic        pready, pslverr, mclk, mdat, e, mclk_q = 1'b0, d_rise;
  logic [3:0]  pin_o, pin_oe, pin_i, strb, fdat;
  logic [1:0]  msel = 2'h0;
  int          miscompares = 0;
  int          compares = 0;
  int          rises = 0, edges_n = 0, s0 = 0, s1 = 0, s3 = 0, b;
  int          dv[3] = '{0, 3, 7};

  always #5 clk = ~clk;
  // the device's own drive wins the shared clock pin
  assign pin_i = (pin_oe & pin_o) | (~pin_oe & {4{mclk}});

  mic_input_ctrl uut (.clk(clk), .reset(reset), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .modulator_data_pin({4{mdat}}), .modulator_clock_pin_i(pin_i),
    .modulator_clock_pin_o(pin_o), .modulator_clock_pin_oe(pin_oe),
    .filter_strobe(strb), .filter_data(fdat));
  mic_mod_model u_mod (.clk(clk), .sel(msel), .mclk(mclk), .mdat(mdat));

  always @(posedge clk) begin
    mclk_q <= mclk;
    if (mclk != mclk_q) edges_n++;
    if (mclk && !mclk_q) rises++;
    if (mclk && !mclk_q) d_rise <= mdat;
    s0 += strb[0];
    s1 += strb[1];
    s3 += strb[3];
  end

  task automatic summarize();
    $display("compares=%0d miscompares=%0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : summarize

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    int n;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 16) begin
      miscompares++;
      summarize();
    end
  endtask : apb

  task automatic rd(input logic [11:0] a, input logic [31:0] x,
                    input logic err);
    apb(1'b0, a, 32'h0000_0000);
    chk(q, x);
    chk({31'h0, e}, {31'h0, err});
  endtask : rd

  // cycles between two rises of the divided clock or of the strobe
  task automatic gap(input logic s, input int exp);
    int n, k;
    logic v, p;
    n = 0;
    k = 0;
    p = 1'b1;
    repeat (300) begin
      @(posedge clk);
      v = s ? strb[2] : pin_o[2];
      if (k > 0) n++;
      if (v && !p) k++;
      if (k == 2) break;
      p = v;
    end
    chk(32'(n), 32'(exp));
    if (k < 2) begin
      miscompares++;
      summarize();
    end
  endtask : gap

  initial begin
    repeat (5) @(posedge clk);
    reset <= 1'b0;
    for (int c = 0; c < 4; c++) begin
      for (int r = 0; r < 3; r++) rd(12'(c * 16 + r * 4), 0, 1'b0);
    end
    rd(12'h00C, 32'h0000_0000, 1'b1);
    rd(12'h040, 32'h0000_0000, 1'b1);
    apb(1'b1, 12'h03C, 32'hFFFF_FFFF);
    chk({31'h0, e}, 32'h0000_0001);
    rd(12'h030, 32'h0000_0000, 1'b0);
    apb(1'b1, 12'h020, 32'h07FF_0000);
    rd(12'h020, 32'h0000_0000, 1'b0);
    apb(1'b1, 12'h010, 32'h0000_0001);
    rd(12'h010, 32'h0000_0001, 1'b0);
    @(posedge clk);
    rises = 0;
    edges_n = 0;
    s0 = 0;
    s1 = 0;
    msel <= 2'h1;
    repeat (400) @(posedge clk);
    msel <= 2'h0;
    repeat (6) @(posedge clk);
    chk(32'(s0), 32'(rises));
    chk(32'(s1), 32'(edges_n));
    chk({31'h0, fdat[0]}, {31'h0, d_rise});
    foreach (dv[i]) begin
      apb(1'b1, 12'h024, 32'(dv[i]));
      apb(1'b1, 12'h020, 32'h0000_0007);
      repeat (2) @(posedge clk);
      chk({28'h0, pin_oe}, 32'h0000_0004);
      gap(1'b0, 2 * (dv[i] + 1));
      gap(1'b1, 4 * (dv[i] + 1));
    end
    apb(1'b1, 12'h020, 32'h0000_0003);
    repeat (2) @(posedge clk);
    chk({28'h0, pin_oe}, 32'h0000_0000);
    msel <= 2'h3;
    apb(1'b1, 12'h030, 32'h0000_0002);
    repeat (12700) @(posedge clk);
    rd(12'h038, 32'h0000_0003, 1'b0);
    rd(12'h038, 32'h0000_0001, 1'b0);
    apb(1'b1, 12'h030, 32'h0000_0000);
    msel <= 2'h2;
    apb(1'b1, 12'h030, 32'h0000_0002);
    repeat (6300) @(posedge clk);
    rd(12'h038, 32'h0000_0000, 1'b0);
    apb(1'b0, 12'h030, 32'h0000_0000);
    chk(q & 32'h07FC_0007, 32'h0024_0002);
    b = s3;
    repeat (120) @(posedge clk);
    chk(32'(s3 - b >= 19 && s3 - b <= 21), 32'h0000_0001);
    summarize();
  end
endmodule : testbench
`default_nettype wire
